// >>> src/gce_pkg.sv
// Package holding the layout and constants of the guest control extension register.
// How it works
// [RULE1] A build without the extension returns all zeros on every read of the register.
// [RULE2] Software checks the extension-present bit of the base guest control before using it; the bench skips the check, as this build implements it.
// [RULE3] Each virtual processing element has its own copy of the register.
// [RULE4] Bit 5 and bits above the fields read as zero and software writes zeros there.
// [RULE5] Bits 9:8 pick which translations the root page walker serves, read-only zero if absent.
// [RULE6] Walk context 00 serves both contexts with software restoring state; 01 is reserved.
// [RULE7] Walk context 10 serves guest-physical to root-physical and a root miss raises an exception.
// [RULE8] Walk context 11 serves root-virtual to root-physical and a guest miss raises a root exception.
// [RULE9] Bits 7:6 are a read-only preset telling whether root attributes alter guest ones.
// [RULE10] Combining 00 means independent, 01 means modified by root, 10 and 11 are reserved.
// [RULE11] With the base cache enable and bit 4 both set, index-invalidate ops run in guest mode.
// [RULE12] With bit 3 set, guest field-change events raise no exception; cleared, they raise one.
// [RULE13] Optional bits are read-only zero when absent and reset to zero when present.
package gce_pkg;
    localparam int unsigned GCE_W = 32;
    localparam logic [4:0] GCE_REG_NUM = 5'h0b;
    localparam logic [2:0] GCE_REG_SEL = 3'h4;
    localparam int unsigned PWC_HI = 9;
    localparam int unsigned PWC_LO = 8;
    localparam int unsigned CCB_HI = 7;
    localparam int unsigned CCB_LO = 6;
    localparam int unsigned CGI_BIT = 4;
    localparam int unsigned FCD_BIT = 3;
    localparam logic [1:0] PWC_RESET = 2'h0;
    localparam logic [15:0] CACHE_IDX_INV_CODE = 16'hb000;
    localparam logic [GCE_W-1:0] GCE_ZERO = 32'h0000_0000;
    typedef enum logic [1:0] {
        GCE_PWC_BOTH,
        GCE_PWC_RSVD,
        GCE_PWC_GUEST,
        GCE_PWC_ROOT
    } gce_pwc_t;
    localparam logic [1:0] CCB_INDEPENDENT = 2'h0;
    localparam logic [1:0] CCB_MODIFIED = 2'h1;
endpackage

// >>> src/gce_vpe_copy.sv
// One copy of the guest control extension register for a single processing element.
`timescale 1ns/10ps
`default_nettype none
module gce_vpe_copy #(
    parameter bit HAS_PWC = 1'b1,
    parameter bit HAS_CGI = 1'b1,
    parameter bit HAS_FCD = 1'b1
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic wr_en,
    input wire logic [gce_pkg::GCE_W-1:0] wr_data,
    output logic [1:0] pwc,
    output logic index_invalidate_enable,
    output logic fcd
);
    import gce_pkg::*;

    // Writable fields; absent features stay zero so they read as zero
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pwc <= PWC_RESET; // [RULE13]
            index_invalidate_enable <= 1'b0; // [RULE13]
            fcd <= 1'b0; // [RULE13]
        end else if (wr_en) begin
            pwc <= HAS_PWC ? wr_data[PWC_HI:PWC_LO] : PWC_RESET; // [RULE5]
            index_invalidate_enable <= HAS_CGI & wr_data[CGI_BIT]; // [RULE13]
            fcd <= HAS_FCD & wr_data[FCD_BIT]; // [RULE13]
        end
    end
endmodule // gce_vpe_copy
`default_nettype wire

// >>> src/gce_reg.sv
// Guest control extension register bank with its steering outputs.
`timescale 1ns/10ps
`default_nettype none
module gce_reg #(
    parameter int unsigned NUM_VPE = 2,
    parameter int unsigned VPE_W = 1,
    parameter bit IMPLEMENTED = 1'b1,
    parameter bit HAS_PWC = 1'b1,
    parameter bit HAS_CGI = 1'b1,
    parameter bit HAS_FCD = 1'b1,
    parameter logic [1:0] CCB_PRESET = gce_pkg::CCB_INDEPENDENT
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cop_wr,
    input wire logic cop_rd,
    input wire logic [4:0] cop_reg_num,
    input wire logic [2:0] cop_reg_sel,
    input wire logic [VPE_W-1:0] cop_vpe,
    input wire logic [gce_pkg::GCE_W-1:0] cop_wr_data,
    output logic [gce_pkg::GCE_W-1:0] cop_rd_data,
    output logic cop_rd_valid,
    input wire logic [VPE_W-1:0] ctx_vpe,
    input wire logic cache_operation_enable,
    input wire logic guest_mode,
    input wire logic cache_op,
    input wire logic [15:0] cache_op_code,
    input wire logic guest_field_change,
    input wire logic root_tlb_miss,
    input wire logic guest_tlb_miss,
    output logic [1:0] page_walk_context_field,
    output logic walk_guest_phys,
    output logic walk_root_virt,
    output logic walk_restore_needed,
    output logic [1:0] cacheability_combining_field,
    output logic cache_op_psi_suppress,
    output logic field_change_exception,
    output logic walk_miss_exception
);
    import gce_pkg::*;

    // Organisation: one copy per processing element, written only by the register bus.
    // The steering outputs follow the element named by ctx_vpe, so a context switch
    // takes effect on the edge after ctx_vpe changes. Everything leaving the block is
    // registered, which costs one cycle on each exception condition but keeps the
    // outputs glitch-free for the pipeline that consumes them.

    // Per-element state gathered from the copies
    logic [1:0] pwc_q [NUM_VPE];
    logic cgi_q [NUM_VPE];
    logic fcd_q [NUM_VPE];
    logic sel_hit;
    logic [1:0] cur_pwc;
    logic cur_cgi;
    logic cur_fcd;
    logic [1:0] next_pwc;
    // Read image of each element, built beside its copy so the read mux is a plain index
    logic [GCE_W-1:0] vpe_word [NUM_VPE];

    // Register decode is shared by reads and writes
    function automatic logic hit(input logic [4:0] num, input logic [2:0] sel);
        hit = (num == GCE_REG_NUM) && (sel == GCE_REG_SEL);
    endfunction

    // Readable image of one copy; reserved bits and absent fields stay zero
    function automatic logic [GCE_W-1:0] pack_word(input logic [1:0] pwc, input logic index_invalidate_enable,
        input logic fcd);
        logic [GCE_W-1:0] word;
        word = GCE_ZERO; // [RULE4]
        word[PWC_HI:PWC_LO] = pwc; // [RULE5]
        word[CCB_HI:CCB_LO] = CCB_PRESET; // [RULE9]
        word[CGI_BIT] = index_invalidate_enable; // [RULE13]
        word[FCD_BIT] = fcd; // [RULE13]
        pack_word = word;
    endfunction

    // Which walker miss escalates depends only on the context being served
    function automatic logic miss_raise(input logic [1:0] ctx, input logic root_miss,
        input logic guest_miss);
        case (gce_pwc_t'(ctx))
            GCE_PWC_GUEST: begin
                miss_raise = root_miss; // [RULE7]
            end
            GCE_PWC_ROOT: begin
                miss_raise = guest_miss; // [RULE8]
            end
            // Shared walking leaves miss handling to software, so nothing escalates here
            default: begin
                miss_raise = 1'b0;
            end
        endcase
    endfunction

    assign sel_hit = hit(cop_reg_num, cop_reg_sel);

    // One copy per processing element; the hardware side never writes it
    genvar g;
    generate
        for (g = 0; g < NUM_VPE; g++) begin : g_vpe
            gce_vpe_copy #(
                .HAS_PWC(HAS_PWC & IMPLEMENTED),
                .HAS_CGI(HAS_CGI & IMPLEMENTED),
                .HAS_FCD(HAS_FCD & IMPLEMENTED)
            ) u_copy (
                .clk(clk),
                .sys_rst(sys_rst),
                .wr_en(cop_wr && sel_hit && (cop_vpe == VPE_W'(g))), // [RULE3]
                .wr_data(cop_wr_data),
                .pwc(pwc_q[g]),
                .index_invalidate_enable(cgi_q[g]),
                .fcd(fcd_q[g])
            );
            // Image of this copy as a read returns it
            assign vpe_word[g] = pack_word(pwc_q[g], cgi_q[g], fcd_q[g]);
        end
    endgenerate

    assign cur_pwc = pwc_q[ctx_vpe];
    assign cur_cgi = cgi_q[ctx_vpe];
    assign cur_fcd = fcd_q[ctx_vpe];
    assign next_pwc = cur_pwc;

    // Read answer: every read strobe is acknowledged, hit or not
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cop_rd_valid <= 1'b0;
        end else begin
            cop_rd_valid <= cop_rd;
        end
    end

    // Read data, one cycle after the request; a read that meets a write in the same
    // cycle still sees the old value because the copies update on that very edge
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cop_rd_data <= GCE_ZERO;
        end else if (cop_rd && sel_hit && IMPLEMENTED) begin
            cop_rd_data <= vpe_word[cop_vpe]; // [RULE3] [RULE5] [RULE9]
        end else begin
            cop_rd_data <= GCE_ZERO; // Absent register or other select [RULE1] [RULE4]
        end
    end

    // Walker steering for the current element; 01 decodes like 00
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            page_walk_context_field <= PWC_RESET;
            walk_guest_phys <= 1'b1;
            walk_root_virt <= 1'b1;
            walk_restore_needed <= 1'b1;
        end else begin
            page_walk_context_field <= next_pwc;
            case (gce_pwc_t'(next_pwc))
                GCE_PWC_GUEST: begin
                    walk_guest_phys <= 1'b1; // [RULE7]
                    walk_root_virt <= 1'b0;
                    walk_restore_needed <= 1'b0;
                end
                GCE_PWC_ROOT: begin
                    walk_guest_phys <= 1'b0; // [RULE8]
                    walk_root_virt <= 1'b1;
                    walk_restore_needed <= 1'b0;
                end
                GCE_PWC_BOTH: begin
                    walk_guest_phys <= 1'b1; // [RULE6]
                    walk_root_virt <= 1'b1;
                    walk_restore_needed <= 1'b1; // [RULE6]
                end
                // Reserved code acts as 00 so a stray write never leaves both walkers off
                GCE_PWC_RSVD: begin
                    walk_guest_phys <= 1'b1;
                    walk_root_virt <= 1'b1;
                    walk_restore_needed <= 1'b1;
                end
                default: begin
                    walk_guest_phys <= 1'b1;
                    walk_root_virt <= 1'b1;
                    walk_restore_needed <= 1'b1;
                end
            endcase
        end
    end

    // Miss escalation for the current element, one cycle after the miss
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            walk_miss_exception <= 1'b0;
        end else begin
            walk_miss_exception <= miss_raise(next_pwc, root_tlb_miss,
                guest_tlb_miss); // [RULE7] [RULE8]
        end
    end

    // Constant preset; reserved codes are the integrator's problem
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cacheability_combining_field <= 2'h0;
        end else begin
            cacheability_combining_field <= IMPLEMENTED ? CCB_PRESET : 2'h0; // [RULE10]
        end
    end

    // Index-invalidate suppression, registered so the output comes from a flop
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cache_op_psi_suppress <= 1'b0;
        end else begin
            cache_op_psi_suppress <= guest_mode && cache_op && cache_operation_enable
                && cur_cgi && (cache_op_code == CACHE_IDX_INV_CODE); // [RULE11]
        end
    end

    // Field-change exception; the disable bit only masks guest-mode events
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            field_change_exception <= 1'b0;
        end else begin
            field_change_exception <= guest_mode && guest_field_change && !cur_fcd; // [RULE12]
        end
    end
endmodule // gce_reg
`default_nettype wire

// >>> testbench/gce_reg_checker.sv
// Port checker for the guest control extension register.
`timescale 1ns/10ps
`default_nettype none
module gce_reg_checker (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cop_rd,
    input wire logic [2:0] cop_reg_sel,
    input wire logic [gce_pkg::GCE_W-1:0] cop_rd_data,
    input wire logic cop_rd_valid,
    input wire logic guest_mode,
    input wire logic [15:0] cache_op_code,
    input wire logic guest_field_change,
    input wire logic root_tlb_miss,
    input wire logic guest_tlb_miss,
    input wire logic [1:0] page_walk_context_field,
    input wire logic walk_guest_phys,
    input wire logic walk_root_virt,
    input wire logic walk_restore_needed,
    input wire logic cache_op_psi_suppress,
    input wire logic field_change_exception,
    input wire logic walk_miss_exception
);
    import gce_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Reads, decode and events all answer one registered cycle later
    a_read_answered: assert property (cop_rd |=> cop_rd_valid) else $error("no read answer");
    a_unmapped_zero: assert property (cop_rd_valid && $past(cop_reg_sel) != GCE_REG_SEL
        |-> cop_rd_data == GCE_ZERO) else $error("unmapped read not zero");
    a_reserved_zero: assert property (cop_rd_valid |-> cop_rd_data[31:10] == 22'h00_0000
        && !cop_rd_data[5]) else $error("reserved bits set");
    a_walk_both: assert property (!page_walk_context_field[1] |-> walk_guest_phys
        && walk_root_virt && walk_restore_needed) else $error("walk 0x decode");
    a_walk_guest: assert property (page_walk_context_field == 2'h2 |-> walk_guest_phys
        && !walk_root_virt && !walk_restore_needed) else $error("walk 10 decode");
    a_walk_root: assert property (page_walk_context_field == 2'h3 |-> !walk_guest_phys
        && walk_root_virt && !walk_restore_needed) else $error("walk 11 decode");
    a_miss_raise: assert property (walk_miss_exception == (page_walk_context_field == 2'h2
        && $past(root_tlb_miss) || page_walk_context_field == 2'h3 && $past(guest_tlb_miss)))
        else $error("miss exception wrong");
    a_psi_cause: assert property (cache_op_psi_suppress |-> $past(guest_mode
        && cache_op_code == CACHE_IDX_INV_CODE)) else $error("suppress without cause");
    a_fce_cause: assert property (field_change_exception |-> $past(guest_mode
        && guest_field_change)) else $error("field exception without cause");
endmodule // gce_reg_checker
`default_nettype wire

// >>> testbench/gce_reg_bench.sv
// Self-checking bench for the guest control extension register.
`timescale 1ns/10ps
`default_nettype none
module gce_reg_bench;
    import gce_pkg::*;
    logic clk = 1'b0, sys_rst = 1'b1, cop_wr = 1'b0, cop_rd = 1'b0, cop_vpe = 1'b0;
    logic ctx_vpe = 1'b0, cache_operation_enable = 1'b0, guest_mode = 1'b0, cache_op = 1'b0;
    logic guest_field_change = 1'b0, root_tlb_miss = 1'b0, guest_tlb_miss = 1'b0;
    logic [4:0] cop_reg_num = 5'h0b;
    logic [2:0] cop_reg_sel = 3'h4;
    logic [31:0] cop_wr_data = 32'h0000_0000, cop_rd_data;
    logic [15:0] cache_op_code = 16'h0000;
    logic [1:0] page_walk_context_field, cacheability_combining_field;
    logic cop_rd_valid, walk_guest_phys, walk_root_virt, walk_restore_needed;
    logic cache_op_psi_suppress, field_change_exception, walk_miss_exception;
    int fails = 0, samples_checked = 0;
    gce_reg i_gce_reg (
        .clk(clk), .sys_rst(sys_rst), .cop_wr(cop_wr), .cop_rd(cop_rd),
        .cop_reg_num(cop_reg_num), .cop_reg_sel(cop_reg_sel), .cop_vpe(cop_vpe),
        .cop_wr_data(cop_wr_data), .cop_rd_data(cop_rd_data), .cop_rd_valid(cop_rd_valid),
        .ctx_vpe(ctx_vpe), .cache_operation_enable(cache_operation_enable),
        .guest_mode(guest_mode), .cache_op(cache_op), .cache_op_code(cache_op_code),
        .guest_field_change(guest_field_change), .root_tlb_miss(root_tlb_miss),
        .guest_tlb_miss(guest_tlb_miss), .page_walk_context_field(page_walk_context_field),
        .walk_guest_phys(walk_guest_phys), .walk_root_virt(walk_root_virt),
        .walk_restore_needed(walk_restore_needed),
        .cacheability_combining_field(cacheability_combining_field),
        .cache_op_psi_suppress(cache_op_psi_suppress),
        .field_change_exception(field_change_exception),
        .walk_miss_exception(walk_miss_exception)
    );
    // Free-running core clock
    initial begin
        forever #25 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Strobes change on the falling edge so the rising edge sees them settled
    task automatic wr(input logic [2:0] sel, input logic vpe, input logic [31:0] d);
        @(negedge clk);
        {cop_wr, cop_reg_sel, cop_vpe, cop_wr_data} = {1'b1, sel, vpe, d};
        @(negedge clk);
        cop_wr = 1'b0;
        @(negedge clk);
    endtask
    task automatic rd(input logic [2:0] sel, input logic vpe, input logic [31:0] exp);
        @(negedge clk);
        {cop_rd, cop_reg_sel, cop_vpe} = {1'b1, sel, vpe};
        @(negedge clk);
        cop_rd = 1'b0;
        chk(cop_rd_valid, 32'h0000_0001);
        chk(cop_rd_data, exp);
    endtask
    // Inputs are guest, cache op, field change and cache enable; result is suppress, exception
    task automatic ev(input logic [3:0] in, input logic [15:0] code, input logic [1:0] exp);
        @(negedge clk);
        {guest_mode, cache_op, guest_field_change, cache_operation_enable} = in;
        cache_op_code = code;
        @(negedge clk);
        chk({cache_op_psi_suppress, field_change_exception}, exp);
    endtask
    // Every walk context encoding, its decode and which miss escalates
    task automatic t_walk;
        logic [2:0] dec [4] = '{3'h7, 3'h7, 3'h4, 3'h2};
        for (int e = 0; e < 4; e++) begin
            wr(GCE_REG_SEL, 1'b0, 32'(e) << 8);
            chk(page_walk_context_field, e);
            chk({walk_guest_phys, walk_root_virt, walk_restore_needed}, dec[e]);
            {root_tlb_miss, guest_tlb_miss} = 2'h2;
            @(negedge clk);
            chk(walk_miss_exception, e == 2);
            {root_tlb_miss, guest_tlb_miss} = 2'h1;
            @(negedge clk);
            chk(walk_miss_exception, e == 3);
            {root_tlb_miss, guest_tlb_miss} = 2'h0;
        end
        // Steering follows the selected element: element 1 was never written
        ctx_vpe = 1'b1;
        @(negedge clk);
        chk(page_walk_context_field, 32'h0000_0000);
        ctx_vpe = 1'b0;
    endtask
    task automatic conclude;
        $display("checks %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Tests need under a hundred cycles; the margin here is generous
    initial begin
        #100000;
        fails++;
        conclude();
    end
    // Software side: the extension is relied on only because this build implements it
    initial begin
        repeat (16) @(posedge clk);
        @(negedge clk);
        sys_rst = 1'b0;
        rd(GCE_REG_SEL, 1'b0, 32'h0000_0000);
        chk(cacheability_combining_field, CCB_INDEPENDENT);
        // Reserved bits are written as zero; the read-only preset bits are tried with ones
        wr(GCE_REG_SEL, 1'b0, 32'h0000_03d8);
        rd(GCE_REG_SEL, 1'b0, 32'h0000_0318);
        wr(3'h3, 1'b1, 32'hffff_ffff);
        rd(3'h3, 1'b1, 32'h0000_0000);
        rd(GCE_REG_SEL, 1'b1, 32'h0000_0000);
        // A write to another register number must leave the fields alone
        cop_reg_num = 5'h0a;
        wr(GCE_REG_SEL, 1'b0, 32'h0000_0000);
        cop_reg_num = GCE_REG_NUM;
        rd(GCE_REG_SEL, 1'b0, 32'h0000_0318);
        t_walk();
        wr(GCE_REG_SEL, 1'b0, 32'h0000_0010);
        ev(4'hd, CACHE_IDX_INV_CODE, 2'h2);
        ev(4'hd, 16'hb001, 2'h0);
        ev(4'hc, CACHE_IDX_INV_CODE, 2'h0);
        ev(4'he, 16'h0000, 2'h1);
        wr(GCE_REG_SEL, 1'b0, 32'h0000_0008);
        ev(4'hf, CACHE_IDX_INV_CODE, 2'h0);
        conclude();
    end
endmodule // gce_reg_bench
bind gce_reg gce_reg_checker i_gce_reg_checker (
    .clk(clk), .sys_rst(sys_rst), .cop_rd(cop_rd), .cop_reg_sel(cop_reg_sel),
    .cop_rd_data(cop_rd_data), .cop_rd_valid(cop_rd_valid), .guest_mode(guest_mode),
    .cache_op_code(cache_op_code), .guest_field_change(guest_field_change),
    .root_tlb_miss(root_tlb_miss), .guest_tlb_miss(guest_tlb_miss),
    .page_walk_context_field(page_walk_context_field), .walk_guest_phys(walk_guest_phys),
    .walk_root_virt(walk_root_virt), .walk_restore_needed(walk_restore_needed),
    .cache_op_psi_suppress(cache_op_psi_suppress),
    .field_change_exception(field_change_exception),
    .walk_miss_exception(walk_miss_exception)
);
`default_nettype wire
